// ===== shared/ports_defines.svh
`ifndef PORTS_DEFINES_SVH
`define PORTS_DEFINES_SVH

// Data-memory addresses of the port registers
`define LOW_OUTPUT_DATA_ADDR 8'hf3
`define HIGH_OUTPUT_DATA_ADDR 8'hf4
`define BIDIR_PORT_DATA_ADDR 8'hf6
`define BIDIR_DIRECTION_CONTROL_ADDR 8'hfc

// Reset values
`define LOW_OUTPUT_DATA_RESET 4'h0
`define HIGH_OUTPUT_DATA_RESET 3'h0
`define BIDIR_PORT_DATA_RESET 4'h0
`define BIDIR_DIRECTION_RESET 1'b0

// Field positions in the high output register
`define HIGH_PIN_0_BIT 0
`define HIGH_PIN_1_BIT 1
`define HIGH_PIN_2_BIT 2

// Direction bit position and value meaning output
`define BIDIR_DIRECTION_BIT 0
`define BIDIR_DIR_OUTPUT 1'b1

// Clock output divider: largest ratio exponent (ratio 128)
`define CLOCK_DIV_LOG2_MAX 7
`define CLOCK_DIV_COUNT_W 7

`endif

// ===== shared/ports_pkg.sv
package ports_pkg;

    // Special function chosen at build time for upper pin 2
    typedef enum logic [1:0]
    {
        HIGH2_PLAIN = 2'h1,
        HIGH2_SPECIAL = 2'h2
    } high2_mode_e;

    typedef struct packed
    {
        logic [6:0] count;
        logic level;
    } divider_state_s;

    typedef struct packed
    {
        logic [3:0] low_data;
        logic [2:0] high_data;
        logic [3:0] bidir_data;
        logic dir_output;
        logic [3:0] sync_stage1;
        logic [3:0] sync_stage2;
        logic [3:0] rdata;
        logic [3:0] low_pins;
        logic [2:0] high_pins;
        logic [3:0] bidir_out;
        logic [3:0] bidir_oe;
    } port_state_s;

endpackage

// ===== src/clock_out_divider.sv
`timescale 1ns/1ns
`include "ports_defines.svh"

module clock_out_divider
#(
    parameter logic [2:0] DIV_LOG2 = 3'h0
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic enable,
    input wire logic half_tick,
    output logic level
);

    localparam logic [6:0] LAST = 7'((8'h01 << DIV_LOG2) - 8'h01);

    ports_pkg::divider_state_s state_q;
    ports_pkg::divider_state_s state_d;

    // Toggle every ratio half periods of the oscillator; stopped output rests low
    always_comb
    begin
        state_d = state_q;
        if (!enable)
        begin
            state_d.count = 7'h00;
            state_d.level = 1'b0;
        end
        else if (half_tick)
        begin
            if (state_q.count == LAST)
            begin
                state_d.count = 7'h00;
                state_d.level = ~state_q.level;
            end
            else
            begin
                state_d.count = state_q.count + 7'h01;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign level = state_q.level;

endmodule // clock_out_divider

// ===== src/output_and_bidir_ports.sv
`timescale 1ns/1ns
`include "ports_defines.svh"

module output_and_bidir_ports
#(
    parameter logic HIGH0_CLOCK_OUT = 1'b0,
    parameter ports_pkg::high2_mode_e HIGH2_MODE = ports_pkg::HIGH2_PLAIN,
    parameter logic HIGH2_ENVELOPE = 1'b0,
    parameter logic [2:0] CLOCK_DIV_LOG2 = 3'h0
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] bus_addr,
    input wire logic [3:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [3:0] bus_rdata,
    input wire logic osc_half_tick,
    input wire logic melody_in,
    input wire logic envelope_in,
    output logic [3:0] low_out_pins,
    output logic high_out_pin_0,
    output logic high_out_pin_1,
    output logic high_out_pin_2,
    input wire logic [3:0] bidir_pins_in,
    output logic [3:0] bidir_pins_out,
    output logic [3:0] bidir_pins_oe
);

    ports_pkg::port_state_s state_q;
    ports_pkg::port_state_s state_d;
    logic clock_output;
    logic clock_enable;
    logic sel_low;
    logic sel_high;
    logic sel_bidir;
    logic sel_dir;

    // Address decode of the four nibble registers
    always_comb
    begin
        sel_low = 1'b0;
        sel_high = 1'b0;
        sel_bidir = 1'b0;
        sel_dir = 1'b0;
        if (bus_addr == `LOW_OUTPUT_DATA_ADDR)
        begin
            sel_low = 1'b1;
        end
        else if (bus_addr == `HIGH_OUTPUT_DATA_ADDR)
        begin
            sel_high = 1'b1;
        end
        else if (bus_addr == `BIDIR_PORT_DATA_ADDR)
        begin
            sel_bidir = 1'b1;
        end
        else if (bus_addr == `BIDIR_DIRECTION_CONTROL_ADDR)
        begin
            sel_dir = 1'b1;
        end
    end

    // Divider runs only when pin 0 is built as clock output and its bit is set
    assign clock_enable = HIGH0_CLOCK_OUT & state_q.high_data[`HIGH_PIN_0_BIT];

    clock_out_divider #(
        .DIV_LOG2(CLOCK_DIV_LOG2)
    ) u_clock_out_divider (
        .clock(clock),
        .rstn(rstn),
        .enable(clock_enable),
        .half_tick(osc_half_tick),
        .level(clock_output)
    );

    always_comb
    begin
        state_d = state_q;

        // Pin synchroniser; stage 1 is read only by stage 2
        state_d.sync_stage1 = bidir_pins_in;
        state_d.sync_stage2 = state_q.sync_stage1;

        // Register writes take the whole nibble, except high (bits 2:0) and direction (bit 0)
        if (bus_write)
        begin
            if (sel_low)
            begin
                state_d.low_data = bus_wdata;
            end
            if (sel_high)
            begin
                state_d.high_data = bus_wdata[2:0];
            end
            if (sel_bidir)
            begin
                state_d.bidir_data = bus_wdata;
            end
            if (sel_dir)
            begin
                state_d.dir_output = bus_wdata[`BIDIR_DIRECTION_BIT];
            end
        end

        // Read data held until the next read
        if (bus_read)
        begin
            state_d.rdata = 4'h0;
            if (sel_low)
            begin
                state_d.rdata = state_q.low_data;
            end
            else if (sel_high)
            begin
                state_d.rdata = {1'b0, state_q.high_data};
            end
            else if (sel_bidir)
            begin
                if (state_q.dir_output)
                begin
                    state_d.rdata = state_q.bidir_data;
                end
                else
                begin
                    state_d.rdata = state_q.sync_stage2;
                end
            end
            else if (sel_dir)
            begin
                state_d.rdata = {3'h0, state_q.dir_output};
            end
        end

        // Pins follow the newly stored values, except upper pin 0 as clock output (divider level) and pin 2 in special mode (bit gated by melody/envelope)
        state_d.low_pins = state_d.low_data;
        state_d.high_pins[1] = state_d.high_data[`HIGH_PIN_1_BIT];
        if (HIGH0_CLOCK_OUT)
        begin
            state_d.high_pins[0] = clock_output;
        end
        else
        begin
            state_d.high_pins[0] = state_d.high_data[`HIGH_PIN_0_BIT];
        end
        if (HIGH2_MODE == ports_pkg::HIGH2_SPECIAL)
        begin
            if (HIGH2_ENVELOPE)
            begin
                state_d.high_pins[2] = state_d.high_data[`HIGH_PIN_2_BIT] & envelope_in;
            end
            else
            begin
                // Inverted melody gated by the pin 2 bit
                state_d.high_pins[2] = state_d.high_data[`HIGH_PIN_2_BIT] & ~melody_in;
            end
        end
        else
        begin
            state_d.high_pins[2] = state_d.high_data[`HIGH_PIN_2_BIT];
        end
        state_d.bidir_out = state_d.bidir_data;
        state_d.bidir_oe = {4{state_d.dir_output == `BIDIR_DIR_OUTPUT}};
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state_q <= '0;
            state_q.low_data <= `LOW_OUTPUT_DATA_RESET;
            state_q.high_data <= `HIGH_OUTPUT_DATA_RESET;
            state_q.bidir_data <= `BIDIR_PORT_DATA_RESET;
            state_q.dir_output <= `BIDIR_DIRECTION_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign bus_rdata = state_q.rdata;
    assign low_out_pins = state_q.low_pins;
    assign high_out_pin_0 = state_q.high_pins[0];
    assign high_out_pin_1 = state_q.high_pins[1];
    assign high_out_pin_2 = state_q.high_pins[2];
    assign bidir_pins_out = state_q.bidir_out;
    assign bidir_pins_oe = state_q.bidir_oe;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    low_write_pins_a: assert property (
        bus_write && bus_addr == `LOW_OUTPUT_DATA_ADDR |=> low_out_pins == $past(bus_wdata))
        else $error("low pins do not follow a low register write");

    low_readback_a: assert property (
        bus_write && bus_addr == `LOW_OUTPUT_DATA_ADDR ##1
        bus_read && bus_addr == `LOW_OUTPUT_DATA_ADDR && !bus_write
        |=> bus_rdata == $past(bus_wdata, 2))
        else $error("low register read does not return written value");

    high_readback_a: assert property (
        bus_read && bus_addr == `HIGH_OUTPUT_DATA_ADDR
        |=> bus_rdata == {1'b0, $past(state_q.high_data)})
        else $error("high register read mismatch");

    input_read_a: assert property (
        bus_read && bus_addr == `BIDIR_PORT_DATA_ADDR && !bidir_pins_oe[0]
        && bidir_pins_in == $past(bidir_pins_in) && bidir_pins_in == $past(bidir_pins_in, 2)
        |=> bus_rdata == $past(bidir_pins_in))
        else $error("input mode read does not show pin levels");

    output_drive_a: assert property (
        bus_write && sel_bidir && bidir_pins_oe == 4'hf |=> bidir_pins_out == $past(bus_wdata))
        else $error("output mode pins differ from held data");

    preload_a: assert property (
        bus_write && bus_addr == `BIDIR_PORT_DATA_ADDR
        |=> state_q.bidir_data == $past(bus_wdata))
        else $error("bidir data write lost");

    output_read_a: assert property (
        bus_read && bus_addr == `BIDIR_PORT_DATA_ADDR && bidir_pins_oe == 4'hf
        |=> bus_rdata == $past(state_q.bidir_data))
        else $error("output mode read does not return held data");

    control_read_a: assert property (
        bus_read && bus_addr == `BIDIR_DIRECTION_CONTROL_ADDR
        |=> bus_rdata[3:1] == 3'h0 && bus_rdata[0] == $past(state_q.dir_output))
        else $error("port control upper bits not zero");

    dir_write_a: assert property (
        bus_write && bus_addr == `BIDIR_DIRECTION_CONTROL_ADDR
        |=> bidir_pins_oe == {4{$past(bus_wdata[0])}})
        else $error("direction write not applied to enables");

    clock_stop_a: assert property (
        !state_q.high_data[0] [*3] |-> !high_out_pin_0)
        else $error("clock output runs with its bit clear");

    unmapped_read_a: assert property (
        bus_read && bus_addr != `LOW_OUTPUT_DATA_ADDR
        && bus_addr != `HIGH_OUTPUT_DATA_ADDR
        && bus_addr != `BIDIR_PORT_DATA_ADDR
        && bus_addr != `BIDIR_DIRECTION_CONTROL_ADDR |=> bus_rdata == 4'h0)
        else $error("unmapped read not zero");

    cover_preload_c: cover property (
        bus_write && bus_addr == `BIDIR_PORT_DATA_ADDR && !bidir_pins_oe[0]
        ##[1:20] bidir_pins_oe == 4'hf);
    cover_clock_run_c: cover property (
        high_out_pin_0 ##1 !high_out_pin_0 ##[1:300] high_out_pin_0);
    cover_input_read_c: cover property (
        bus_read && bus_addr == `BIDIR_PORT_DATA_ADDR && !bidir_pins_oe[0]);
    cover_rmw_c: cover property (
        bus_read && bus_addr == `LOW_OUTPUT_DATA_ADDR
        ##1 bus_write && bus_addr == `LOW_OUTPUT_DATA_ADDR);

endmodule // output_and_bidir_ports

// ===== verif/pin_partner.sv
`timescale 1ns/1ns

module pin_partner
(
    input wire logic [3:0] drive_out,
    input wire logic [3:0] drive_oe,
    input wire logic [3:0] ext_value,
    output logic [3:0] level
);
    // A pin follows the chip while the chip drives it, else the attached circuit
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            level[i] = drive_oe[i] ? drive_out[i] : ext_value[i];
        end
    end
endmodule // pin_partner

// ===== verif/output_and_bidir_ports_tb.sv
`timescale 1ns/1ns
`include "ports_defines.svh"

module output_and_bidir_ports_tb;
    logic clock;
    logic rstn;
    logic [7:0] bus_addr;
    logic [3:0] bus_wdata;
    logic bus_write;
    logic bus_read;
    logic [3:0] bus_rdata;
    logic osc_half_tick;
    logic tick_en;
    logic melody_in;
    logic [3:0] low_out_pins;
    logic high_out_pin_0;
    logic high_out_pin_1;
    logic high_out_pin_2;
    logic plain_pin_0;
    logic plain_pin_1;
    logic plain_pin_2;
    logic [3:0] pin_level;
    logic [3:0] bidir_pins_out;
    logic [3:0] bidir_pins_oe;
    logic [3:0] ext_drive;
    logic prev;
    int miscompares;
    int n_compared;
    int cycles;
    int toggles;

    output_and_bidir_ports
    #(
        .HIGH0_CLOCK_OUT(1'b1),
        .HIGH2_MODE(ports_pkg::HIGH2_SPECIAL),
        .HIGH2_ENVELOPE(1'b0),
        .CLOCK_DIV_LOG2(3'h1)
    )
    i_dut
    (
        .clock(clock),
        .rstn(rstn),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_write(bus_write),
        .bus_read(bus_read),
        .bus_rdata(bus_rdata),
        .osc_half_tick(osc_half_tick),
        .melody_in(melody_in),
        .envelope_in(1'b0),
        .low_out_pins(low_out_pins),
        .high_out_pin_0(high_out_pin_0),
        .high_out_pin_1(high_out_pin_1),
        .high_out_pin_2(high_out_pin_2),
        .bidir_pins_in(pin_level),
        .bidir_pins_out(bidir_pins_out),
        .bidir_pins_oe(bidir_pins_oe)
    );

    pin_partner i_pins
    (
        .drive_out(bidir_pins_out),
        .drive_oe(bidir_pins_oe),
        .ext_value(ext_drive),
        .level(pin_level)
    );

    // Same registers built with plain DC output on upper pins 0 and 2
    output_and_bidir_ports
    #(
        .HIGH0_CLOCK_OUT(1'b0),
        .HIGH2_MODE(ports_pkg::HIGH2_PLAIN),
        .HIGH2_ENVELOPE(1'b0),
        .CLOCK_DIV_LOG2(3'h0)
    )
    i_dut_plain
    (
        .clock(clock),
        .rstn(rstn),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_write(bus_write),
        .bus_read(bus_read),
        .bus_rdata(),
        .osc_half_tick(osc_half_tick),
        .melody_in(melody_in),
        .envelope_in(1'b0),
        .low_out_pins(),
        .high_out_pin_0(plain_pin_0),
        .high_out_pin_1(plain_pin_1),
        .high_out_pin_2(plain_pin_2),
        .bidir_pins_in(pin_level),
        .bidir_pins_out(),
        .bidir_pins_oe()
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Oscillator half-period pulse on every other system cycle
    always @(negedge clock)
    begin
        osc_half_tick <= tick_en & ~osc_half_tick;
    end

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_write = 1'b1;
        @(negedge clock);
        bus_write = 1'b0;
        // Idle cycle keeps back-to-back strobes apart
        @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] exp, input string what);
        bus_addr = a;
        bus_read = 1'b1;
        @(negedge clock);
        bus_read = 1'b0;
        chk(what, exp, bus_rdata);
        @(negedge clock);
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        rstn = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 4'h0;
        bus_write = 1'b0;
        bus_read = 1'b0;
        tick_en = 1'b0;
        melody_in = 1'b0;
        ext_drive = 4'ha;
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        chk("low_pins_reset", 4'h0, low_out_pins);
        chk("oe_reset", 4'h0, bidir_pins_oe);
        chk("bidir_data_reset", 4'h0, bidir_pins_out);
        rd(`LOW_OUTPUT_DATA_ADDR, 4'h0, "low_reset");
        rd(`HIGH_OUTPUT_DATA_ADDR, 4'h0, "high_reset");
        rd(`BIDIR_DIRECTION_CONTROL_ADDR, 4'h0, "dir_reset");
        rd(`BIDIR_PORT_DATA_ADDR, 4'ha, "bidir_in_reset");
        for (int i = 0; i < 16; i++)
        begin
            wr(`LOW_OUTPUT_DATA_ADDR, 4'(i));
            chk("low_pins", 4'(i), low_out_pins);
            rd(`LOW_OUTPUT_DATA_ADDR, 4'(i), "low_readback");
        end
        wr(`BIDIR_PORT_DATA_ADDR, 4'h5);
        chk("oe_input", 4'h0, bidir_pins_oe);
        rd(`BIDIR_PORT_DATA_ADDR, 4'ha, "bidir_in_pins");
        wr(`BIDIR_DIRECTION_CONTROL_ADDR, 4'hf);
        chk("oe_output", 4'hf, bidir_pins_oe);
        chk("bidir_preload", 4'h5, bidir_pins_out);
        rd(`BIDIR_DIRECTION_CONTROL_ADDR, 4'h1, "dir_upper_zero");
        rd(`BIDIR_PORT_DATA_ADDR, 4'h5, "bidir_out_read");
        wr(`BIDIR_PORT_DATA_ADDR, 4'hc);
        chk("bidir_drive", 4'hc, bidir_pins_out);
        wr(`BIDIR_DIRECTION_CONTROL_ADDR, 4'h0);
        ext_drive = 4'h3;
        repeat (3) @(negedge clock);
        rd(`BIDIR_PORT_DATA_ADDR, 4'h3, "bidir_back_in");
        wr(8'hf5, 4'h0);
        rd(8'hf5, 4'h0, "unmapped_read");
        rd(`LOW_OUTPUT_DATA_ADDR, 4'hf, "low_untouched");
        wr(`HIGH_OUTPUT_DATA_ADDR, 4'h2);
        chk("high_pins", 4'h2, {1'b0, high_out_pin_2, high_out_pin_1, high_out_pin_0});
        chk("plain_high_pins", 4'h2, {1'b0, plain_pin_2, plain_pin_1, plain_pin_0});
        rd(`HIGH_OUTPUT_DATA_ADDR, 4'h2, "high_readback");
        wr(`HIGH_OUTPUT_DATA_ADDR, 4'h4);
        repeat (2) @(negedge clock);
        chk("melody_quiet", 4'h1, {3'h0, high_out_pin_2});
        melody_in = 1'b1;
        repeat (2) @(negedge clock);
        chk("melody_inverted", 4'h0, {3'h0, high_out_pin_2});
        chk("plain_pin2", 4'h1, {3'h0, plain_pin_2});
        tick_en = 1'b1;
        wr(`HIGH_OUTPUT_DATA_ADDR, 4'h1);
        toggles = 0;
        prev = high_out_pin_0;
        repeat (32)
        begin
            @(negedge clock);
            if (high_out_pin_0 !== prev)
                toggles++;
            prev = high_out_pin_0;
        end
        chk("clock_rate", 4'h1, {3'h0, toggles >= 7 && toggles <= 9});
        chk("plain_pin0", 4'h1, {3'h0, plain_pin_0});
        wr(`HIGH_OUTPUT_DATA_ADDR, 4'h0);
        repeat (2) @(negedge clock);
        toggles = 0;
        repeat (8)
        begin
            @(negedge clock);
            if (high_out_pin_0 !== 1'b0)
                toggles++;
        end
        chk("clock_stopped", 4'h0, 4'(toggles));
        stop_test();
    end
endmodule // output_and_bidir_ports_tb
